/* File: include/trim_pkg.sv */
// Package: constants and carrier types for the per-sample gain and offset trim block
package trim_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 16;
	localparam int SAMPLE_W    = 14;
	localparam int GAIN_CODE_W = 5;
	localparam int OFFSET_W    = 10;
	localparam int FACTOR_W    = 16;
	localparam int FACTOR_FRAC = 14;
	localparam int TRIM_COUNT  = 4;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTRL3_ADDR      = 8'h03;
	localparam logic [ADDR_W-1:0] CONV6_ODD_ADDR  = 8'h1b;
	localparam logic [ADDR_W-1:0] CONV6_EVEN_ADDR = 8'h1c;
	localparam logic [ADDR_W-1:0] CONV7_ODD_ADDR  = 8'h1d;
	localparam logic [ADDR_W-1:0] CONV7_EVEN_ADDR = 8'h1e;
	localparam logic [ADDR_W-1:0] SAT_STATUS_ADDR = 8'h3f;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int GAIN_HI       = 15;
	localparam int GAIN_LO       = 11;
	localparam int RSVD_BIT      = 10;
	localparam int OFFSET_HI     = 9;
	localparam int OFFSET_LO     = 0;
	localparam int GAIN_EN_BIT   = 12;
	localparam int OFFSET_EN_BIT = 8;

	// ------------------------------------------------------------------
	// Reset values and arithmetic constants
	// ------------------------------------------------------------------
	localparam logic [DATA_W-1:0]          TRIM_RESET  = 16'h0000;
	localparam logic [DATA_W-1:0]          CTRL3_RESET = 16'h0000;
	localparam logic [DATA_W-1:0]          READ_ZERO   = 16'h0000;
	localparam logic [FACTOR_W-1:0]        GAIN_UNITY  = 16'h4000;
	localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX  = 14'sh1fff;
	localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN  = -14'sh2000;
	localparam logic signed [32:0]         ROUND_HALF  = 33'sh000002000;
	localparam int                         LANE_LATENCY = 1;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                       valid;
		logic                       odd;
		logic signed [SAMPLE_W-1:0] data;
	} sample_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_bus_type;

	typedef struct packed {
		logic [FACTOR_W-1:0]        odd_factor;
		logic [FACTOR_W-1:0]        even_factor;
		logic signed [OFFSET_W-1:0] odd_offset;
		logic signed [OFFSET_W-1:0] even_offset;
		logic                       gain_en;
		logic                       offset_en;
	} trim_set_type;

endpackage

/* File: logic/trim_lane.sv */
// Module: one converter lane applying odd/even offset and gain trim
`timescale 1ns/1ns
module trim_lane (
	input  wire logic                 sys_clk,
	input  wire logic                 arst_n,
	input  wire trim_pkg::sample_type   sample_in,
	input  wire trim_pkg::trim_set_type trim,
	output      trim_pkg::sample_type   sample_out,
	output      logic                   saturated
);
	import trim_pkg::*;

	typedef struct packed {
		sample_type out;
		logic       sat;
	} lane_state_type;

	lane_state_type state;
	lane_state_type next_state;

	// ------------------------------------------------------------------
	// Datapath: offset subtract, gain multiply, round, saturate
	// ------------------------------------------------------------------
	always_comb begin
		logic [FACTOR_W-1:0]        factor;
		logic signed [OFFSET_W-1:0] offset;
		logic signed [SAMPLE_W:0]   diff;
		logic signed [32:0]         prod;
		logic signed [32:0]         scaled;
		factor = trim.even_factor;
		offset = trim.even_offset;
		diff = '0;
		prod = '0;
		scaled = '0;
		next_state = state;
		next_state.sat = 1'b0;
		next_state.out.valid = sample_in.valid;
		// Odd samples take the odd setting, even the even one
		if (sample_in.odd) begin
			factor = trim.odd_factor;
			offset = trim.odd_offset;
		end
		// Disabled controls fall back to unity gain and zero offset
		if (!trim.gain_en) begin
			factor = GAIN_UNITY;
		end
		if (!trim.offset_en) begin
			offset = '0;
		end
		// Signed offset weighs one sample lsb
		diff = 15'(sample_in.data) - 15'(offset);
		prod = 33'(diff) * 33'($signed({1'b0, factor}));
		scaled = (prod + ROUND_HALF) >>> FACTOR_FRAC;
		if (sample_in.valid) begin
			next_state.out.odd = sample_in.odd;
			if (scaled > 33'(SAMPLE_MAX)) begin
				next_state.out.data = SAMPLE_MAX;
				next_state.sat = 1'b1;
			end else if (scaled < 33'(SAMPLE_MIN)) begin
				next_state.out.data = SAMPLE_MIN;
				next_state.sat = 1'b1;
			end else begin
				next_state.out.data = scaled[SAMPLE_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sample_out = state.out;
	assign saturated  = state.sat;

endmodule

/* File: logic/per_sample_gain_offset_trim.sv */
// Module: gain and offset trim for converters 6 and 7 with its register file
//
// Operation
// - Gain code in bits 15..11 gives gain of code times 0.2 dB.
// - Gain codes act only while gain-enable, control bit 12, is one.
// - Offset in bits 9..0 is subtracted while control bit 8 is one.
// - Offset is signed two's complement, one unit per 14-bit sample lsb.
// - Setting at 1Bh trims odd samples of converter 6.
// - Setting at 1Ch trims even samples of converter 6, independently.
// - Setting at 1Dh trims odd samples of converter 7.
// - Setting at 1Eh trims even samples of converter 7, independently.
`timescale 1ns/1ns
module per_sample_gain_offset_trim (
	input  wire logic                     sys_clk,
	input  wire logic                     arst_n,
	input  wire trim_pkg::reg_bus_type      bus,
	output      logic [trim_pkg::DATA_W-1:0] rd_data,
	input  wire trim_pkg::sample_type       conv6_in,
	input  wire trim_pkg::sample_type       conv7_in,
	output      trim_pkg::sample_type       conv6_out,
	output      trim_pkg::sample_type       conv7_out,
	output      logic                       gain_correction_enable,
	output      logic                       offset_correction_enable
);
	import trim_pkg::*;

	// ------------------------------------------------------------------
	// Register indices within the trim array
	// ------------------------------------------------------------------
	localparam int IDX_C6_ODD  = 0;
	localparam int IDX_C6_EVEN = 1;
	localparam int IDX_C7_ODD  = 2;
	localparam int IDX_C7_EVEN = 3;

	// ------------------------------------------------------------------
	// Whole block state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [TRIM_COUNT-1:0][DATA_W-1:0] trim;
		logic [DATA_W-1:0]                 ctrl3;
		logic [1:0]                        sat_flags;
		logic [DATA_W-1:0]                 rd_data;
	} block_state_type;

	block_state_type state;
	block_state_type next_state;

	trim_set_type conv6_trim;
	trim_set_type conv7_trim;
	logic         conv6_sat;
	logic         conv7_sat;

	// ------------------------------------------------------------------
	// Gain code to linear factor, 14 fraction bits, 10^(code/100)
	// ------------------------------------------------------------------
	function automatic logic [FACTOR_W-1:0] gain_factor(input logic [GAIN_CODE_W-1:0] code);
		logic [FACTOR_W-1:0] f;
		f = GAIN_UNITY;
		case (code)
			5'h00: f = 16'h4000;
			5'h01: f = 16'h417e;
			5'h02: f = 16'h4304;
			5'h03: f = 16'h4494;
			5'h04: f = 16'h462d;
			5'h05: f = 16'h47cf;
			5'h06: f = 16'h497b;
			5'h07: f = 16'h4b32;
			5'h08: f = 16'h4cf2;
			5'h09: f = 16'h4ebd;
			5'h0a: f = 16'h5092;
			5'h0b: f = 16'h5273;
			5'h0c: f = 16'h545f;
			5'h0d: f = 16'h5656;
			5'h0e: f = 16'h5858;
			5'h0f: f = 16'h5a67;
			5'h10: f = 16'h5c82;
			5'h11: f = 16'h5eaa;
			5'h12: f = 16'h60de;
			5'h13: f = 16'h6320;
			5'h14: f = 16'h656f;
			5'h15: f = 16'h67cc;
			5'h16: f = 16'h6a37;
			5'h17: f = 16'h6cb0;
			5'h18: f = 16'h6f38;
			5'h19: f = 16'h71d0;
			5'h1a: f = 16'h7476;
			5'h1b: f = 16'h772d;
			5'h1c: f = 16'h79f3;
			5'h1d: f = 16'h7cca;
			5'h1e: f = 16'h7fb2;
			5'h1f: f = 16'h82ac;
			default: f = GAIN_UNITY;
		endcase
		return f;
	endfunction

	// ------------------------------------------------------------------
	// Field extraction helpers
	// ------------------------------------------------------------------
	function automatic logic [GAIN_CODE_W-1:0] gain_code(input logic [DATA_W-1:0] word);
		return word[GAIN_HI:GAIN_LO];
	endfunction

	function automatic logic signed [OFFSET_W-1:0] offset_value(input logic [DATA_W-1:0] word);
		return $signed(word[OFFSET_HI:OFFSET_LO]);
	endfunction

	// ------------------------------------------------------------------
	// Named fields of the four trim words
	// ------------------------------------------------------------------
	logic [GAIN_CODE_W-1:0]     conv6_odd_gain_code;
	logic [GAIN_CODE_W-1:0]     conv6_even_gain_code;
	logic [GAIN_CODE_W-1:0]     conv7_odd_gain_code;
	logic [GAIN_CODE_W-1:0]     conv7_even_gain_code;
	logic signed [OFFSET_W-1:0] conv6_odd_offset_value;
	logic signed [OFFSET_W-1:0] conv6_even_offset_value;
	logic signed [OFFSET_W-1:0] conv7_odd_offset_value;
	logic signed [OFFSET_W-1:0] conv7_even_offset_value;

	// Gain code sits in 15..11, offset in 9..0; bit 10 feeds nothing
	assign conv6_odd_gain_code     = gain_code(state.trim[IDX_C6_ODD]);
	assign conv6_even_gain_code    = gain_code(state.trim[IDX_C6_EVEN]);
	assign conv7_odd_gain_code     = gain_code(state.trim[IDX_C7_ODD]);
	assign conv7_even_gain_code    = gain_code(state.trim[IDX_C7_EVEN]);
	assign conv6_odd_offset_value  = offset_value(state.trim[IDX_C6_ODD]);
	assign conv6_even_offset_value = offset_value(state.trim[IDX_C6_EVEN]);
	assign conv7_odd_offset_value  = offset_value(state.trim[IDX_C7_ODD]);
	assign conv7_even_offset_value = offset_value(state.trim[IDX_C7_EVEN]);

	// ------------------------------------------------------------------
	// Global enables from control register 3
	// ------------------------------------------------------------------
	assign gain_correction_enable   = state.ctrl3[GAIN_EN_BIT];
	assign offset_correction_enable = state.ctrl3[OFFSET_EN_BIT];

	// ------------------------------------------------------------------
	// Converter 6 settings: odd from 1Bh, even from 1Ch
	// ------------------------------------------------------------------
	always_comb begin
		conv6_trim             = '0;
		conv6_trim.odd_factor  = gain_factor(conv6_odd_gain_code);
		conv6_trim.odd_offset  = conv6_odd_offset_value;
		conv6_trim.even_factor = gain_factor(conv6_even_gain_code);
		conv6_trim.even_offset = conv6_even_offset_value;
		conv6_trim.gain_en     = gain_correction_enable;
		conv6_trim.offset_en   = offset_correction_enable;
	end

	// ------------------------------------------------------------------
	// Converter 7 settings: odd from 1Dh, even from 1Eh
	// ------------------------------------------------------------------
	always_comb begin
		conv7_trim             = '0;
		conv7_trim.odd_factor  = gain_factor(conv7_odd_gain_code);
		conv7_trim.odd_offset  = conv7_odd_offset_value;
		conv7_trim.even_factor = gain_factor(conv7_even_gain_code);
		conv7_trim.even_offset = conv7_even_offset_value;
		conv7_trim.gain_en     = gain_correction_enable;
		conv7_trim.offset_en   = offset_correction_enable;
	end

	// ------------------------------------------------------------------
	// Lanes
	// ------------------------------------------------------------------
	// Converter 6 datapath
	trim_lane conv6_lane (
		.sys_clk    (sys_clk),
		.arst_n     (arst_n),
		.sample_in  (conv6_in),
		.trim       (conv6_trim),
		.sample_out (conv6_out),
		.saturated  (conv6_sat)
	);

	// Converter 7 datapath
	trim_lane conv7_lane (
		.sys_clk    (sys_clk),
		.arst_n     (arst_n),
		.sample_in  (conv7_in),
		.trim       (conv7_trim),
		.sample_out (conv7_out),
		.saturated  (conv7_sat)
	);

	// ------------------------------------------------------------------
	// Register writes, read answer and saturation flags
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.rd_data = READ_ZERO;

		// Write decode; the word is stored as given, bit 10 included
		if (bus.wr) begin
			if (bus.addr == CTRL3_ADDR) begin
				next_state.ctrl3 = bus.wdata;
			end else if (bus.addr == CONV6_ODD_ADDR) begin
				next_state.trim[IDX_C6_ODD] = bus.wdata;
			end else if (bus.addr == CONV6_EVEN_ADDR) begin
				next_state.trim[IDX_C6_EVEN] = bus.wdata;
			end else if (bus.addr == CONV7_ODD_ADDR) begin
				next_state.trim[IDX_C7_ODD] = bus.wdata;
			end else if (bus.addr == CONV7_EVEN_ADDR) begin
				next_state.trim[IDX_C7_EVEN] = bus.wdata;
			end else if (bus.addr == SAT_STATUS_ADDR) begin
				// Write one to clear
				next_state.sat_flags = state.sat_flags & ~bus.wdata[1:0];
			end
		end

		// New saturation events win over a clear in the same cycle
		if (conv6_sat) begin
			next_state.sat_flags[0] = 1'b1;
		end
		if (conv7_sat) begin
			next_state.sat_flags[1] = 1'b1;
		end

		// Read decode; unmapped addresses answer zero
		if (bus.rd) begin
			if (bus.addr == CTRL3_ADDR) begin
				next_state.rd_data = state.ctrl3;
			end else if (bus.addr == CONV6_ODD_ADDR) begin
				next_state.rd_data = state.trim[IDX_C6_ODD];
			end else if (bus.addr == CONV6_EVEN_ADDR) begin
				next_state.rd_data = state.trim[IDX_C6_EVEN];
			end else if (bus.addr == CONV7_ODD_ADDR) begin
				next_state.rd_data = state.trim[IDX_C7_ODD];
			end else if (bus.addr == CONV7_EVEN_ADDR) begin
				next_state.rd_data = state.trim[IDX_C7_EVEN];
			end else if (bus.addr == SAT_STATUS_ADDR) begin
				next_state.rd_data = {14'h0000, state.sat_flags};
			end else begin
				next_state.rd_data = READ_ZERO;
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state.trim      <= {TRIM_COUNT{TRIM_RESET}};
			state.ctrl3     <= CTRL3_RESET;
			state.sat_flags <= 2'h0;
			state.rd_data   <= READ_ZERO;
		end else begin
			state <= next_state;
		end
	end

	assign rd_data = state.rd_data;

endmodule

/* File: verif/trim_chk.sv */
// Checker: port-level timing and enable relations of the trim block
`timescale 1ns/1ns
module trim_chk (
	input wire logic                        sys_clk,
	input wire logic                        arst_n,
	input wire trim_pkg::reg_bus_type       bus,
	input wire logic [trim_pkg::DATA_W-1:0] rd_data,
	input wire trim_pkg::sample_type        conv6_in,
	input wire trim_pkg::sample_type        conv7_in,
	input wire trim_pkg::sample_type        conv6_out,
	input wire trim_pkg::sample_type        conv7_out,
	input wire logic                        gain_correction_enable,
	input wire logic                        offset_correction_enable
);
	import trim_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// ------------------------------------------------------------------
	// Lane timing
	// ------------------------------------------------------------------
	lane6_valid_a: assert property (1 |=> conv6_out.valid == $past(conv6_in.valid))
		else $error("conv6 output valid not one cycle after input");
	lane7_valid_a: assert property (1 |=> conv7_out.valid == $past(conv7_in.valid))
		else $error("conv7 output valid not one cycle after input");
	hold_data_a: assert property (!conv6_in.valid |=> $stable(conv6_out.data))
		else $error("conv6 output data moved without a sample");

	// ------------------------------------------------------------------
	// Bypass with both enables cleared
	// ------------------------------------------------------------------
	bypass_six_a: assert property (conv6_in.valid && !gain_correction_enable
		&& !offset_correction_enable |=> conv6_out.data == $past(conv6_in.data))
		else $error("conv6 sample altered with corrections off");
	bypass_seven_a: assert property (conv7_in.valid && !gain_correction_enable
		&& !offset_correction_enable |=> conv7_out.data == $past(conv7_in.data))
		else $error("conv7 sample altered with corrections off");

	// ------------------------------------------------------------------
	// Control enables and read port
	// ------------------------------------------------------------------
	enable_write_a: assert property (bus.wr && bus.addr == CTRL3_ADDR |=>
		gain_correction_enable == $past(bus.wdata[GAIN_EN_BIT])
		&& offset_correction_enable == $past(bus.wdata[OFFSET_EN_BIT]))
		else $error("enable outputs do not follow control write");
	enable_hold_a: assert property (!(bus.wr && bus.addr == CTRL3_ADDR) |=>
		$stable(gain_correction_enable) && $stable(offset_correction_enable))
		else $error("enable outputs changed without control write");
	enable_read_a: assert property (bus.rd && bus.addr == CTRL3_ADDR |=>
		rd_data[12] == gain_correction_enable && rd_data[8] == offset_correction_enable)
		else $error("control readback disagrees with enables");
	read_idle_a: assert property (!bus.rd |=> rd_data == 16'h0000)
		else $error("read data not zero outside read answer");
endmodule

bind per_sample_gain_offset_trim trim_chk u_trim_chk (.sys_clk(sys_clk), .arst_n(arst_n),
	.bus(bus), .rd_data(rd_data), .conv6_in(conv6_in), .conv7_in(conv7_in),
	.conv6_out(conv6_out), .conv7_out(conv7_out),
	.gain_correction_enable(gain_correction_enable),
	.offset_correction_enable(offset_correction_enable));

/* File: verif/per_sample_gain_offset_trim_bench.sv */
// Testbench: register access and sample trim scenarios for the trim block
`timescale 1ns/1ns
module per_sample_gain_offset_trim_bench;
	import trim_pkg::*;
	logic              sys_clk;
	logic              arst_n;
	reg_bus_type       bus;
	logic [DATA_W-1:0] rd_data;
	sample_type        conv6_in;
	sample_type        conv7_in;
	sample_type        conv6_out;
	sample_type        conv7_out;
	logic              gain_correction_enable;
	logic              offset_correction_enable;
	int                bad_count;
	int                n_tests;
	logic [ADDR_W-1:0] trim_addr [TRIM_COUNT];

	per_sample_gain_offset_trim u_per_sample_gain_offset_trim (.sys_clk(sys_clk),
		.arst_n(arst_n), .bus(bus), .rd_data(rd_data), .conv6_in(conv6_in),
		.conv7_in(conv7_in), .conv6_out(conv6_out), .conv7_out(conv7_out),
		.gain_correction_enable(gain_correction_enable),
		.offset_correction_enable(offset_correction_enable));

	// ------------------------------------------------------------------
	// Clock and helpers
	// ------------------------------------------------------------------
	always #2 sys_clk = ~sys_clk;

	task automatic check(input bit ok, input string msg);
		n_tests++;
		if (!ok) begin
			bad_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1;
		check(rd_data === e, "read data mismatch");
	endtask

	// Index 0 conv6 odd, 1 conv6 even, 2 conv7 odd, 3 conv7 even
	task automatic lane_send(input int idx, input int d, input logic [SAMPLE_W-1:0] e);
		@(posedge sys_clk);
		if (idx < 2) conv6_in <= '{valid: 1'b1, odd: (idx % 2 == 0), data: SAMPLE_W'(d)};
		else conv7_in <= '{valid: 1'b1, odd: (idx % 2 == 0), data: SAMPLE_W'(d)};
		@(posedge sys_clk);
		conv6_in.valid <= 1'b0;
		conv7_in.valid <= 1'b0;
		#1;
		// Odd flag must travel with the sample it belongs to
		if (idx < 2) check(conv6_out.valid === 1'b1 && conv6_out.data === e
			&& conv6_out.odd === (idx % 2 == 0), "conv6 sample");
		else check(conv7_out.valid === 1'b1 && conv7_out.data === e
			&& conv7_out.odd === (idx % 2 == 0), "conv7 sample");
	endtask

	// Offset first, then gain, round half up, clip to 14 bits
	function automatic logic [SAMPLE_W-1:0] exp_val(input int d, input int off, input int fac);
		int v;
		v = ((d - off) * fac + 8192) >>> 14;
		if (v > 8191) v = 8191;
		if (v < -8192) v = -8192;
		return SAMPLE_W'(v);
	endfunction

	function automatic logic [DATA_W-1:0] word(input int code, input int off);
		return {5'(code), 1'b0, 10'(off)};
	endfunction

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < TRIM_COUNT; i++) reg_rd(trim_addr[i], TRIM_RESET);
		reg_rd(CTRL3_ADDR, CTRL3_RESET);
	endtask

	task automatic t_readback();
		for (int i = 0; i < TRIM_COUNT; i++) reg_wr(trim_addr[i], word(i + 3, 7 * i + 1));
		for (int i = 0; i < TRIM_COUNT; i++) reg_rd(trim_addr[i], word(i + 3, 7 * i + 1));
		reg_rd(8'h55, READ_ZERO);
	endtask

	task automatic t_bypass();
		reg_wr(CTRL3_ADDR, 16'h0000);
		for (int i = 0; i < TRIM_COUNT; i++) lane_send(i, -1234 + i, SAMPLE_W'(-1234 + i));
	endtask

	task automatic t_offset();
		int off [TRIM_COUNT] = '{5, -3, 511, -512};
		for (int i = 0; i < TRIM_COUNT; i++) reg_wr(trim_addr[i], word(31, off[i]));
		reg_wr(CTRL3_ADDR, 16'h0100);
		// Enables settle only after the write edge
		@(negedge sys_clk);
		check(offset_correction_enable === 1'b1 && gain_correction_enable === 1'b0, "enables");
		for (int i = 0; i < TRIM_COUNT; i++) lane_send(i, 100, exp_val(100, off[i], 16384));
		lane_send(3, 8000, exp_val(8000, -512, 16384));
		lane_send(0, -8192, exp_val(-8192, 5, 16384));
		// conv7 clipped above, conv6 clipped below: sticky flags, then write one to clear conv6 only
		reg_rd(SAT_STATUS_ADDR, 16'h0003);
		reg_wr(SAT_STATUS_ADDR, 16'h0001);
		reg_rd(SAT_STATUS_ADDR, 16'h0002);
	endtask

	task automatic t_gain();
		reg_wr(trim_addr[0], word(1, 0));
		reg_wr(trim_addr[1], word(0, 0));
		reg_wr(trim_addr[2], word(31, 0));
		reg_wr(trim_addr[3], word(31, -512));
		reg_wr(CTRL3_ADDR, 16'h1000);
		lane_send(0, 1000, exp_val(1000, 0, 16766));
		lane_send(1, 1000, exp_val(1000, 0, 16384));
		lane_send(2, 8000, exp_val(8000, 0, 33452));
		lane_send(3, 1000, exp_val(1000, 0, 33452));
		reg_wr(CTRL3_ADDR, 16'h1100);
		lane_send(3, 1000, exp_val(1000, -512, 33452));
		reg_rd(CTRL3_ADDR, 16'h1100);
	endtask

	// ------------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ------------------------------------------------------------------
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		#20000;
		bad_count++;
		end_sim();
	end

	initial begin
		sys_clk = 1'b0;
		arst_n = 1'b0;
		bus = '0;
		conv6_in = '0;
		conv7_in = '0;
		bad_count = 0;
		n_tests = 0;
		trim_addr = '{CONV6_ODD_ADDR, CONV6_EVEN_ADDR, CONV7_ODD_ADDR, CONV7_EVEN_ADDR};
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset();
		t_readback();
		t_bypass();
		t_offset();
		t_gain();
		end_sim();
	end
endmodule
